// [pkg/jtp_pkg.sv]
package jtp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths and depths
    localparam int IR_W      = 8;
    localparam int DR_W      = 56;
    localparam int ID_W      = 32;
    localparam int SIG_W     = 32;
    localparam int ADDR_W    = 4;
    localparam int CFG_DEPTH = 16;

    typedef logic [DR_W-1:0]   jtp_dr_t;
    typedef logic [IR_W-1:0]   jtp_ir_t;
    typedef logic [ADDR_W-1:0] jtp_addr_t;
    typedef logic [SIG_W-1:0]  jtp_sig_t;

    ////////////////////////////////////////////////////////////////////////
    // tap controller states
    typedef enum logic [3:0] {
        ST_TLR    = 4'h0,
        ST_RTI    = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SH_DR  = 4'h4,
        ST_EX1_DR = 4'h5,
        ST_PAU_DR = 4'h6,
        ST_EX2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'hA,
        ST_SH_IR  = 4'hB,
        ST_EX1_IR = 4'hC,
        ST_PAU_IR = 4'hD,
        ST_EX2_IR = 4'hE,
        ST_UPD_IR = 4'hF
    } jtp_state_e;

    ////////////////////////////////////////////////////////////////////////
    // instruction codes
    localparam jtp_ir_t INS_EXTEST       = 8'h00;
    localparam jtp_ir_t INS_BULK_ERASE   = 8'h03;
    localparam jtp_ir_t INS_PROG_FUSE    = 8'h09;
    localparam jtp_ir_t INS_DISCHARGE    = 8'h14;
    localparam jtp_ir_t INS_PROG_ENABLE  = 8'h15;
    localparam jtp_ir_t INS_ID_READ      = 8'h16;
    localparam jtp_ir_t INS_SIG_READ     = 8'h17;
    localparam jtp_ir_t INS_SIG_PROG     = 8'h1A;
    localparam jtp_ir_t INS_SAMPLE       = 8'h1C;
    localparam jtp_ir_t INS_PROG_DISABLE = 8'h1E;
    localparam jtp_ir_t INS_DEV_RESET    = 8'h22;
    localparam jtp_ir_t INS_DONE_ERASE   = 8'h24;
    localparam jtp_ir_t INS_CFG_VERIFY   = 8'h28;
    localparam jtp_ir_t INS_CFG_ERASE    = 8'h29;
    localparam jtp_ir_t INS_CFG_ADDRESS  = 8'h2B;
    localparam jtp_ir_t INS_CFG_SHIFT    = 8'h2D;
    localparam jtp_ir_t INS_CFG_PROG     = 8'h2E;
    localparam jtp_ir_t INS_DONE_PROG    = 8'h2F;
    localparam jtp_ir_t INS_BYPASS       = 8'hFF;

    // instruction register after reset and in capture
    localparam jtp_ir_t IR_RESET = INS_ID_READ;

    // identification word, value arbitrary
    localparam logic [ID_W-1:0] ID_VALUE = 32'h1234_5001;

    ////////////////////////////////////////////////////////////////////////
    // index of the bit that takes tdi, per data path
    localparam logic [5:0] MSB_ID   = 6'h1F;
    localparam logic [5:0] MSB_SIG  = 6'h1F;
    localparam logic [5:0] MSB_ADDR = 6'h03;
    localparam logic [5:0] MSB_CFG  = 6'h37;
    localparam logic [5:0] MSB_BYP  = 6'h00;

    ////////////////////////////////////////////////////////////////////////
    // nonvolatile operations and their timing
    localparam logic [7:0] NV_OP_CYCLES = 8'h10;
    localparam jtp_sig_t   SIG_RESET    = 32'h0000_0000;

    typedef enum logic [3:0] {
        OP_NONE       = 4'h0,
        OP_CFG_PROG   = 4'h1,
        OP_CFG_ERASE  = 4'h2,
        OP_BULK_ERASE = 4'h3,
        OP_FUSE_PROG  = 4'h4,
        OP_SIG_PROG   = 4'h5,
        OP_DONE_PROG  = 4'h6,
        OP_DONE_ERASE = 4'h7,
        OP_CFG_READ   = 4'h8,
        OP_SIG_READ   = 4'h9
    } jtp_op_e;

    // request passed from the test clock to the system clock
    typedef struct packed {
        jtp_op_e   op;
        logic      prog_en;
        jtp_addr_t addr;
        jtp_dr_t   data;
    } jtp_req_s;

endpackage

// [rtl/jtp_bit_sync.sv]
`timescale 1ns/10ps
module jtp_bit_sync (
    // destination clock
    input  logic clk,
    input  logic rst_n,
    // level in, level out
    input  logic d,
    output logic q
);

    logic meta_q;

    // two flops, the first read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// [rtl/jtp_tap_fsm.sv]
`timescale 1ns/10ps
module jtp_tap_fsm (
    // test clock side
    input  logic                tck,
    input  logic                rst_n,
    input  logic                tms,
    // controller state
    output jtp_pkg::jtp_state_e state_q
);

    jtp_pkg::jtp_state_e state_d;

    // next state from tms
    always_comb begin
        state_d = state_q;
        case (state_q)
            jtp_pkg::ST_TLR:    state_d = tms ? jtp_pkg::ST_TLR
                                              : jtp_pkg::ST_RTI;
            jtp_pkg::ST_RTI:    state_d = tms ? jtp_pkg::ST_SEL_DR
                                              : jtp_pkg::ST_RTI;
            jtp_pkg::ST_SEL_DR: state_d = tms ? jtp_pkg::ST_SEL_IR
                                              : jtp_pkg::ST_CAP_DR;
            jtp_pkg::ST_CAP_DR: state_d = tms ? jtp_pkg::ST_EX1_DR
                                              : jtp_pkg::ST_SH_DR;
            jtp_pkg::ST_SH_DR:  state_d = tms ? jtp_pkg::ST_EX1_DR
                                              : jtp_pkg::ST_SH_DR;
            jtp_pkg::ST_EX1_DR: state_d = tms ? jtp_pkg::ST_UPD_DR
                                              : jtp_pkg::ST_PAU_DR;
            jtp_pkg::ST_PAU_DR: state_d = tms ? jtp_pkg::ST_EX2_DR
                                              : jtp_pkg::ST_PAU_DR;
            jtp_pkg::ST_EX2_DR: state_d = tms ? jtp_pkg::ST_UPD_DR
                                              : jtp_pkg::ST_SH_DR;
            jtp_pkg::ST_UPD_DR: state_d = tms ? jtp_pkg::ST_SEL_DR
                                              : jtp_pkg::ST_RTI;
            jtp_pkg::ST_SEL_IR: state_d = tms ? jtp_pkg::ST_TLR
                                              : jtp_pkg::ST_CAP_IR;
            jtp_pkg::ST_CAP_IR: state_d = tms ? jtp_pkg::ST_EX1_IR
                                              : jtp_pkg::ST_SH_IR;
            jtp_pkg::ST_SH_IR:  state_d = tms ? jtp_pkg::ST_EX1_IR
                                              : jtp_pkg::ST_SH_IR;
            jtp_pkg::ST_EX1_IR: state_d = tms ? jtp_pkg::ST_UPD_IR
                                              : jtp_pkg::ST_PAU_IR;
            jtp_pkg::ST_PAU_IR: state_d = tms ? jtp_pkg::ST_EX2_IR
                                              : jtp_pkg::ST_PAU_IR;
            jtp_pkg::ST_EX2_IR: state_d = tms ? jtp_pkg::ST_UPD_IR
                                              : jtp_pkg::ST_SH_IR;
            jtp_pkg::ST_UPD_IR: state_d = tms ? jtp_pkg::ST_SEL_DR
                                              : jtp_pkg::ST_RTI;
            default:            state_d = jtp_pkg::ST_TLR;
        endcase
    end

    // state register, starts in test-logic-reset
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= jtp_pkg::ST_TLR;
        end else begin
            state_q <= state_d;
        end
    end

endmodule

// [rtl/jtp_tap_port.sv]
// Summary of operation
// - sixteen-state controller clocked by tck, steered by tms.
// - tdi and tms are sampled on rising tck; host sets them earlier.
// - tdo changes only on falling tck edges.
// - six holding states; only test-logic-reset holds with tms high.
// - five rising edges with tms high reach test-logic-reset from anywhere.
// - controller starts in test-logic-reset at power-up.
// - reset leads to idle; idle does nothing unless an operation is pending.
// - data and instruction branches match, each opening with capture.
// - capture-dr loads the path selected by the current instruction.
// - capture-ir loads the identification-read instruction.
// - capture goes to shift or exit1 by tms.
// - after shift comes exit1, then update to idle or pause.
// - pause leads to exit2, then back to shift or update.
// - program, erase, verify instructions start on next entry to idle.
// - all other instructions take effect in the update state.
// - decoded instruction selects data path and operation for later scans.
// - 32-bit user signature is stored and programmable.
// - once the security fuse is set, configuration readout is blocked.
// - the fuse clears only by a full bulk erase or by rst_n.
// - programming uses only tck, tms, tdi and tdo.
// - eight-bit instruction register; all ones selects one-bit bypass.
// - identification path is a 32-bit shift register.
// - sample/preload and external-test act as bypass.
`timescale 1ns/10ps
module jtp_tap_port (
    // system clock and reset
    input  logic                     clk,
    input  logic                     rst_n,
    // serial test port
    input  logic                     tck,
    input  logic                     tms,
    input  logic                     tdi,
    output logic                     tdo,
    output logic                     tdo_oe,
    // stored state
    output logic [jtp_pkg::SIG_W-1:0] user_signature,
    output logic                     readout_security_fuse,
    output logic                     done_bit,
    output logic                     nv_busy
);

    ////////////////////////////////////////////////////////////////////////
    // test clock domain declarations
    jtp_pkg::jtp_state_e state_q;
    jtp_pkg::jtp_ir_t    ir_sh_q;
    jtp_pkg::jtp_ir_t    ir_q;
    jtp_pkg::jtp_dr_t    dr_q;
    jtp_pkg::jtp_dr_t    dr_shift;
    jtp_pkg::jtp_dr_t    cap_val;
    logic [5:0]          dr_msb;
    jtp_pkg::jtp_addr_t  addr_q;
    jtp_pkg::jtp_dr_t    cfg_data_q;
    jtp_pkg::jtp_sig_t   sig_data_q;
    logic                prog_en_q;
    logic                pend_q;
    jtp_pkg::jtp_op_e    issue_op;
    logic                issue;
    jtp_pkg::jtp_req_s   req_q;
    logic                req_tgl_q;
    logic                ack_sync;
    logic                ack_seen_q;
    logic                link_busy;
    jtp_pkg::jtp_dr_t    rd_hold_q;
    logic                tdo_q;
    logic                tdo_oe_q;

    // system clock domain declarations
    logic                req_sync;
    logic                req_seen_q;
    logic                start;
    jtp_pkg::jtp_dr_t    cfg_mem [jtp_pkg::CFG_DEPTH];
    jtp_pkg::jtp_sig_t   sig_q;
    logic                fuse_q;
    logic                done_q;
    jtp_pkg::jtp_dr_t    rd_q;
    logic [7:0]          cnt_q;
    logic [7:0]          cnt_d;
    logic                busy_q;
    logic                ack_tgl_q;
    logic                wr_ok;

    ////////////////////////////////////////////////////////////////////////
    // instruction decode to nonvolatile operation
    function automatic jtp_pkg::jtp_op_e op_of(input jtp_pkg::jtp_ir_t ir);
        case (ir)
            jtp_pkg::INS_BULK_ERASE: op_of = jtp_pkg::OP_BULK_ERASE;
            jtp_pkg::INS_PROG_FUSE:  op_of = jtp_pkg::OP_FUSE_PROG;
            jtp_pkg::INS_SIG_PROG:   op_of = jtp_pkg::OP_SIG_PROG;
            jtp_pkg::INS_DONE_PROG:  op_of = jtp_pkg::OP_DONE_PROG;
            jtp_pkg::INS_DONE_ERASE: op_of = jtp_pkg::OP_DONE_ERASE;
            jtp_pkg::INS_CFG_VERIFY: op_of = jtp_pkg::OP_CFG_READ;
            jtp_pkg::INS_CFG_ERASE:  op_of = jtp_pkg::OP_CFG_ERASE;
            jtp_pkg::INS_CFG_PROG:   op_of = jtp_pkg::OP_CFG_PROG;
            jtp_pkg::INS_SIG_READ:   op_of = jtp_pkg::OP_SIG_READ;
            default:                 op_of = jtp_pkg::OP_NONE;
        endcase
    endfunction

    // operations held back until idle
    function automatic logic deferred(input jtp_pkg::jtp_ir_t ir);
        deferred = (op_of(ir) != jtp_pkg::OP_NONE)
                 && (op_of(ir) != jtp_pkg::OP_SIG_READ);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // controller, pins sampled on rising tck
    jtp_tap_fsm u_fsm (
        .tck     (tck),
        .rst_n   (rst_n),
        .tms     (tms),
        .state_q (state_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // instruction shift and update
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_q <= jtp_pkg::IR_RESET;
            ir_q    <= jtp_pkg::IR_RESET;
        end else begin
            case (state_q)
                jtp_pkg::ST_TLR:    ir_q    <= jtp_pkg::IR_RESET;
                jtp_pkg::ST_CAP_IR: ir_sh_q <= jtp_pkg::INS_ID_READ;
                jtp_pkg::ST_SH_IR:  ir_sh_q <= {tdi, ir_sh_q[7:1]};
                jtp_pkg::ST_UPD_IR: ir_q    <= ir_sh_q;
                default:            ir_q    <= ir_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data path length by instruction, others fall to bypass
    always_comb begin
        case (ir_q)
            jtp_pkg::INS_ID_READ:     dr_msb = jtp_pkg::MSB_ID;
            jtp_pkg::INS_SIG_READ:    dr_msb = jtp_pkg::MSB_SIG;
            jtp_pkg::INS_CFG_ADDRESS: dr_msb = jtp_pkg::MSB_ADDR;
            jtp_pkg::INS_CFG_SHIFT:   dr_msb = jtp_pkg::MSB_CFG;
            default:                  dr_msb = jtp_pkg::MSB_BYP;
        endcase
    end

    // parallel value loaded in capture-dr
    always_comb begin
        case (ir_q)
            jtp_pkg::INS_ID_READ:
                cap_val = jtp_pkg::jtp_dr_t'(jtp_pkg::ID_VALUE);
            jtp_pkg::INS_SIG_READ:
                cap_val = jtp_pkg::jtp_dr_t'(rd_hold_q[jtp_pkg::SIG_W-1:0]);
            jtp_pkg::INS_CFG_SHIFT:
                cap_val = rd_hold_q;
            jtp_pkg::INS_CFG_ADDRESS:
                cap_val = jtp_pkg::jtp_dr_t'(addr_q);
            default:
                cap_val = '0;
        endcase
    end

    // serial step: tdi enters at the top of the selected path
    genvar gi;
    for (gi = 0; gi < jtp_pkg::DR_W; gi++) begin : g_dr
        if (gi == jtp_pkg::DR_W - 1) begin : g_top
            assign dr_shift[gi] = (dr_msb == 6'(gi)) ? tdi : 1'b0;
        end else begin : g_mid
            assign dr_shift[gi] = (dr_msb == 6'(gi)) ? tdi : dr_q[gi+1];
        end
    end

    // data register capture and shift
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            dr_q <= '0;
        end else if (state_q == jtp_pkg::ST_CAP_DR) begin
            dr_q <= cap_val;
        end else if (state_q == jtp_pkg::ST_SH_DR) begin
            dr_q <= dr_shift;
        end
    end

    // update-dr loads the holding registers
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            addr_q     <= '0;
            cfg_data_q <= '0;
            sig_data_q <= jtp_pkg::SIG_RESET;
        end else if (state_q == jtp_pkg::ST_UPD_DR) begin
            if (ir_q == jtp_pkg::INS_CFG_ADDRESS) begin
                addr_q <= dr_q[jtp_pkg::ADDR_W-1:0];
            end else if (ir_q == jtp_pkg::INS_CFG_SHIFT) begin
                cfg_data_q <= dr_q;
            end else if (ir_q == jtp_pkg::INS_SIG_READ) begin
                sig_data_q <= dr_q[jtp_pkg::SIG_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program mode and pending operation
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            prog_en_q <= 1'b0;
            pend_q    <= 1'b0;
        end else if (state_q == jtp_pkg::ST_TLR) begin
            prog_en_q <= 1'b0;
            pend_q    <= 1'b0;
        end else if (state_q == jtp_pkg::ST_UPD_IR) begin
            if (ir_sh_q == jtp_pkg::INS_PROG_ENABLE) begin
                prog_en_q <= 1'b1;
            end else if (ir_sh_q == jtp_pkg::INS_PROG_DISABLE) begin
                prog_en_q <= 1'b0;
            end
            pend_q <= deferred(ir_sh_q);
        end else if (issue && state_q == jtp_pkg::ST_RTI) begin
            pend_q <= 1'b0;
        end
    end

    // pick the operation to launch this edge
    always_comb begin
        issue_op = jtp_pkg::OP_NONE;
        if (state_q == jtp_pkg::ST_UPD_IR
            && op_of(ir_sh_q) == jtp_pkg::OP_SIG_READ) begin
            issue_op = jtp_pkg::OP_SIG_READ;
        end else if (state_q == jtp_pkg::ST_RTI && pend_q) begin
            issue_op = op_of(ir_q);
        end
    end

    assign link_busy = req_tgl_q ^ ack_sync;
    assign issue     = (issue_op != jtp_pkg::OP_NONE) && !link_busy;

    // request word and toggle towards the system clock
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            req_q     <= '0;
            req_tgl_q <= 1'b0;
        end else if (issue) begin
            req_q.op      <= issue_op;
            req_q.prog_en <= prog_en_q;
            req_q.addr    <= addr_q;
            req_q.data    <= (issue_op == jtp_pkg::OP_SIG_PROG)
                           ? jtp_pkg::jtp_dr_t'(sig_data_q) : cfg_data_q;
            req_tgl_q     <= ~req_tgl_q;
        end
    end

    // acknowledge back from the system clock
    jtp_bit_sync u_ack (
        .clk   (tck),
        .rst_n (rst_n),
        .d     (ack_tgl_q),
        .q     (ack_sync)
    );

    // read result taken once the acknowledge arrives
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ack_seen_q <= 1'b0;
            rd_hold_q  <= '0;
        end else begin
            ack_seen_q <= ack_sync;
            if (ack_sync ^ ack_seen_q) begin
                rd_hold_q <= rd_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial output on falling tck, driven only while shifting
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q    <= (state_q == jtp_pkg::ST_SH_IR) ? ir_sh_q[0]
                                                       : dr_q[0];
            tdo_oe_q <= (state_q == jtp_pkg::ST_SH_IR)
                     || (state_q == jtp_pkg::ST_SH_DR);
        end
    end

    assign tdo    = tdo_q;
    assign tdo_oe = tdo_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // system clock side: request detection
    jtp_bit_sync u_req (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (req_tgl_q),
        .q     (req_sync)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_seen_q <= 1'b0;
        end else begin
            req_seen_q <= req_sync;
        end
    end

    assign start = req_sync ^ req_seen_q;
    assign wr_ok = start && req_q.prog_en;

    // configuration cells
    always_ff @(posedge clk) begin
        if (wr_ok && req_q.op == jtp_pkg::OP_CFG_PROG) begin
            cfg_mem[req_q.addr] <= req_q.data;
        end else if (wr_ok && (req_q.op == jtp_pkg::OP_CFG_ERASE
                            || req_q.op == jtp_pkg::OP_BULK_ERASE)) begin
            for (int i = 0; i < jtp_pkg::CFG_DEPTH; i++) begin
                cfg_mem[i] <= '0;
            end
        end
    end

    // signature, security fuse and done cells
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sig_q  <= jtp_pkg::SIG_RESET;
            fuse_q <= 1'b0;
            done_q <= 1'b0;
        end else if (wr_ok) begin
            case (req_q.op)
                jtp_pkg::OP_SIG_PROG:
                    sig_q <= req_q.data[jtp_pkg::SIG_W-1:0];
                jtp_pkg::OP_FUSE_PROG:  fuse_q <= 1'b1;
                jtp_pkg::OP_DONE_PROG:  done_q <= 1'b1;
                jtp_pkg::OP_DONE_ERASE: done_q <= 1'b0;
                jtp_pkg::OP_BULK_ERASE: begin
                    sig_q  <= jtp_pkg::SIG_RESET;
                    fuse_q <= 1'b0;
                    done_q <= 1'b0;
                end
                default:                done_q <= done_q;
            endcase
        end
    end

    // readout, configuration masked by the fuse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= '0;
        end else if (start && req_q.op == jtp_pkg::OP_CFG_READ) begin
            rd_q <= fuse_q ? '0 : cfg_mem[req_q.addr];
        end else if (start && req_q.op == jtp_pkg::OP_SIG_READ) begin
            rd_q <= jtp_pkg::jtp_dr_t'(sig_q);
        end
    end

    // operation timer
    always_comb begin
        if (start) begin
            cnt_d = jtp_pkg::NV_OP_CYCLES;
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end else begin
            cnt_d = cnt_q;
        end
    end

    // timer, busy flag and acknowledge toggle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q     <= 8'h00;
            busy_q    <= 1'b0;
            ack_tgl_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= (cnt_d != 8'h00);
            if (cnt_q == 8'h01) begin
                ack_tgl_q <= ~ack_tgl_q;
            end
        end
    end

    assign user_signature        = sig_q;
    assign readout_security_fuse = fuse_q;
    assign done_bit              = done_q;
    assign nv_busy               = busy_q;

endmodule

// [testbench/jtp_tap_props.sv]
`timescale 1ns/10ps
module jtp_tap_props (
    // clocks and reset
    input logic                      clk,
    input logic                      rst_n,
    input logic                      tck,
    // serial port
    input logic                      tms,
    input logic                      tdi,
    input logic                      tdo,
    input logic                      tdo_oe,
    // stored state
    input logic [jtp_pkg::SIG_W-1:0] user_signature,
    input logic                      readout_security_fuse,
    input logic                      done_bit,
    input logic                      nv_busy
);
    // reference tap state, next state picked from nibble tables
    localparam logic [63:0] NXT_LO = 64'h1BDD_BBA1_4664_4311;
    localparam logic [63:0] NXT_HI = 64'h2FEF_CC02_8785_5920;
    logic [3:0]             st_q;
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n)
            st_q <= 4'h0;
        else
            st_q <= tms ? NXT_HI[{st_q, 2'h0}+:4] : NXT_LO[{st_q, 2'h0}+:4];
    end
    // test clock domain
    oe_in_shift_a: assert property (@(posedge tck) disable iff (!rst_n)
        tdo_oe == (st_q == 4'h4 || st_q == 4'hB)) else $error("oe wrong");
    ir_capture_a: assert property (@(posedge tck) disable iff (!rst_n)
        (st_q == 4'hA && !tms) ##1 !tms |-> !tdo ##1 tdo)
        else $error("capture-ir word wrong");
    exit_one_a: assert property (@(posedge tck) disable iff (!rst_n)
        tdo_oe && tms |=> !tdo_oe) else $error("shift not left");
    five_high_a: assert property (@(posedge tck) disable iff (!rst_n)
        tms [*5] ##1 !tms [*2] |=> !tdo_oe) else $error("no tap reset");
    // system clock domain
    tdo_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(tdo) |-> !tck) else $error("tdo moved with tck high");
    busy_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(nv_busy) |-> nv_busy [*8] ##1 nv_busy [*8] ##1 !nv_busy)
        else $error("busy length wrong");
    fuse_by_op_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(readout_security_fuse) |-> ##[0:1] nv_busy)
        else $error("fuse moved without operation");
    sig_by_op_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(user_signature) |-> ##[0:1] nv_busy)
        else $error("signature moved without operation");
    // main scenarios
    cover property (@(posedge clk) $rose(nv_busy));
    cover property (@(posedge clk) $fell(readout_security_fuse));
    cover property (@(posedge clk) $rose(done_bit));
endmodule
bind jtp_tap_port jtp_tap_props jtp_tap_props_inst (.clk, .rst_n, .tck,
    .tms, .tdi, .tdo, .tdo_oe, .user_signature, .readout_security_fuse,
    .done_bit, .nv_busy);

// [testbench/jtp_host_model.sv]
`timescale 1ns/10ps
module jtp_host_model (
    // four-wire test port, far side
    output logic tck,
    output logic tms,
    output logic tdi,
    input  logic tdo
);
    // tck stands low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // n bits lsb first, 80 ns period, tdo taken at rising tck
    task automatic frame(input logic [63:0] tm, ti, input int n,
                         output logic [63:0] to);
        to = '0;
        for (int i = 0; i < n; i++) begin
            tms = tm[i];
            tdi = ti[i];
            #20 tck = 1'b1;
            to[i] = tdo;
            #40 tck = 1'b0;
            #20;
        end
    endtask
endmodule

// [testbench/jtp_tap_port_bench.sv]
`timescale 1ns/10ps
module jtp_tap_port_bench;
    // one case: instruction, data length, compare flag, data in, data out
    typedef struct packed {
        logic [7:0]  ir;
        logic [7:0]  len;
        logic        chk;
        logic [55:0] din;
        logic [55:0] dout;
    } jtp_row_s;
    localparam logic [55:0] CW = 56'hC0FF_EE12_3456_78;
    localparam logic [55:0] SW = 56'h5A5A_C3C3;
    localparam jtp_row_s    ROWS [17] = '{
        '{8'hFF, 8'h08, 1'b1, 56'hA5, 56'h4A},
        '{8'h00, 8'h08, 1'b1, 56'hA5, 56'h4A},
        '{8'h1C, 8'h08, 1'b1, 56'hA5, 56'h4A},
        '{8'h16, 8'h20, 1'b1, 56'h0, jtp_pkg::ID_VALUE},
        '{8'h15, 8'h00, 1'b0, 56'h0, 56'h0},
        '{8'h2B, 8'h04, 1'b0, 56'h3, 56'h0},
        '{8'h2D, 8'h38, 1'b0, CW, 56'h0},
        '{8'h2E, 8'h00, 1'b0, 56'h0, 56'h0},
        '{8'h28, 8'h00, 1'b0, 56'h0, 56'h0},
        '{8'h2D, 8'h38, 1'b1, 56'h0, CW},
        '{8'h17, 8'h20, 1'b1, SW, 56'h0},
        '{8'h1A, 8'h00, 1'b0, 56'h0, 56'h0},
        '{8'h17, 8'h20, 1'b1, 56'h0, SW},
        '{8'h09, 8'h00, 1'b0, 56'h0, 56'h0},
        '{8'h28, 8'h00, 1'b0, 56'h0, 56'h0},
        '{8'h2D, 8'h38, 1'b1, 56'h0, 56'h0},
        '{8'h2F, 8'h00, 1'b0, 56'h0, 56'h0}};
    logic        clk, rst_n, tck, tms, tdi, tdo, tdo_oe;
    logic [31:0] user_signature;
    logic        readout_security_fuse, done_bit, nv_busy;
    int          miscompares, checks;
    // design, far-side host, system clock
    jtp_tap_port jtp_tap_port_inst (.clk, .rst_n, .tck, .tms, .tdi, .tdo,
        .tdo_oe, .user_signature, .readout_security_fuse, .done_bit,
        .nv_busy);
    jtp_host_model jtp_host_model_inst (.tck, .tms, .tdi,
        .tdo(tdo_oe ? tdo : ~tdo)); // released pin reads inverted
    initial clk = 1'b0;
    always #2 clk = ~clk;
    task automatic check(input logic [63:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // instruction scan, 10 idle edges, optional data scan; ends in idle
    task automatic scan(input logic [7:0] ir, len, input logic [55:0] din,
                        output logic [63:0] to);
        jtp_host_model_inst.frame(64'h1803, {52'h0, ir, 4'h0}, 14, to);
        check(to[11:4], 8'h16);
        jtp_host_model_inst.frame(64'h0, 64'h0, 10, to);
        if (len != 8'h00) begin
            jtp_host_model_inst.frame(64'h1 | (64'h3 << (len + 2)),
                {5'h0, din, 3'h0}, len + 5, to);
            to = (to >> 3) & ~(64'hFFFF_FFFF_FFFF_FFFF << len);
        end
    endtask
    // bound on the whole run
    initial begin
        #300000;
        miscompares++;
        complete_run();
    end
    initial begin
        logic [63:0] to;
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        jtp_host_model_inst.frame(64'h1F, 64'h0, 7, to);
        foreach (ROWS[r]) begin
            scan(ROWS[r].ir, ROWS[r].len, ROWS[r].din, to);
            if (ROWS[r].chk) check(to, {8'h00, ROWS[r].dout});
        end
        check(readout_security_fuse, 1'b1);
        check(done_bit, 1'b1);
        check(user_signature, SW[31:0]);
        // bulk erase clears fuse, done and signature
        scan(8'h03, 8'h00, 56'h0, to);
        check({readout_security_fuse, done_bit, user_signature}, 34'h0);
        // tap reset from inside a data shift, then a blind id read
        jtp_host_model_inst.frame(64'h3E1, 64'h0, 11, to);
        jtp_host_model_inst.frame(64'h1 | (64'h3 << 34), 64'h0, 37, to);
        check(to[34:3], jtp_pkg::ID_VALUE);
        // no program mode after the tap reset
        scan(8'h2F, 8'h00, 56'h0, to);
        check(done_bit, 1'b0);
        complete_run();
    end
endmodule
